// ===== design/frp_pkg.sv
// Purpose: Constants and types of the frequency protection block
// Assumes: 250 MHz clock, byte addressed Wishbone map
// Notes:   Frequencies and gradients are plain binary codes
package frp_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_ELEM = 6;
  localparam int NUM_PH   = 3;
  localparam int FW       = 16;
  localparam int GW       = 17;
  localparam logic [3:0] WIN_MIN   = 4'h2;
  localparam logic [3:0] WIN_MAX   = 4'hA;
  localparam logic [3:0] WIN_RST   = 4'h2;
  localparam logic [3:0] STABF_RST = 4'h3;
  localparam logic [3:0] STABG_RST = 4'h1;
  localparam logic [15:0] VBLOCK_RST = 16'h0100;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_KHZ       = 250000;
  localparam int BLOCK_HOLD_MS = 500;
  localparam int FREQ_HOLD_MS  = 300;
  localparam int BLOCK_HOLD_CYC = BLOCK_HOLD_MS * CLK_KHZ;
  localparam int FREQ_HOLD_CYC  = FREQ_HOLD_MS * CLK_KHZ;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ADR_VBLOCK = 8'h00;
  localparam logic [7:0] ADR_WINCFG = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_GRAD0  = 8'h0C;
  localparam logic [3:0] ELEM_BASE  = 4'h4;
  localparam logic [1:0] EL_MODE  = 2'h0;
  localparam logic [1:0] EL_FTHR  = 2'h1;
  localparam logic [1:0] EL_GTHR  = 2'h2;
  localparam logic [1:0] EL_DELAY = 2'h3;
  localparam int WIN_LSB   = 0;
  localparam int STABF_LSB = 8;
  localparam int STABG_LSB = 16;
  localparam int POL_LSB   = 4;
  localparam int TRIP_LSB  = 8;
  localparam int BLK_BIT   = 16;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    M_OFF = 3'h0, M_UNDER = 3'h1, M_OVER = 3'h2,
    M_GRAD = 3'h3, M_UNDER_GRAD = 3'h4, M_OVER_GRAD = 3'h5
  } frp_mode_t;
  typedef enum logic [1:0] {P_POS = 2'h0, P_NEG = 2'h1, P_ABS = 2'h2} frp_pol_t;
  typedef enum logic [2:0] {
    S_RUN = 3'b001, S_BLOCKED = 3'b010, S_RECOVER = 3'b100
  } frp_blk_t;
endpackage

// ===== design/frp_top.sv
// Purpose: Six frequency / rate-of-change protection elements
// Assumes: Measurement front end on the same clock, one pulse per period
// Notes:   Gradient is frequency change over the window, in frequency codes
//
// Summary of operation
// - Underfrequency alarms at once below pickup
// - Underfrequency trips after full delay below pickup
// - Overfrequency alarms at once above pickup
// - Overfrequency trips after full delay above pickup
// - All three voltages low blocks frequency
// - Gradient computed per period at zero crossing
// - Gradient window two to ten periods
// - Gradient uses raw, unaveraged frequency
// - Frequency settling window, default three periods
// - Gradient stabilising window in periods
// - Gradient signed, positive means rising
// - Polarity: rise, fall or absolute
// - Gradient violation alarms and starts timer
// - Gradient trip if violation holds at expiry
// - Combined mode alarms on both conditions
// - Combined trip needs both at expiry
// - External block suppresses alarm and timer
// - Hold block 0.5 s, frequency zero 0.3 s
// - Six elements, each with own mode
`timescale 1ns/1ps
module frp_top #(
  parameter int BLOCK_HOLD = frp_pkg::BLOCK_HOLD_CYC,
  parameter int FREQ_HOLD  = frp_pkg::FREQ_HOLD_CYC
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Measurement front end
  input  wire logic [15:0] LINE_VOLTAGE_A_B,
  input  wire logic [15:0] LINE_VOLTAGE_B_C,
  input  wire logic [15:0] LINE_VOLTAGE_C_A,
  input  wire logic [15:0] FREQ_A_B,
  input  wire logic [15:0] FREQ_B_C,
  input  wire logic [15:0] FREQ_C_A,
  input  wire logic [2:0]  ZERO_CROSS,
  // Element control and results
  input  wire logic [5:0]  ELEM_BLOCK,
  output logic      [5:0]  ALARM,
  output logic      [5:0]  TRIP,
  output logic             FREQ_BLOCKED
);
  localparam int NE = frp_pkg::NUM_ELEM;
  localparam int NP = frp_pkg::NUM_PH;
  localparam int FW = frp_pkg::FW;
  localparam int GW = frp_pkg::GW;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic elem_hit(input logic [7:0] adr, input logic [2:0] e);
    return (adr[7:4] == frp_pkg::ELEM_BASE + {1'b0, e}) && (adr[1:0] == 2'h0);
  endfunction

  function automatic logic ph_pick(input frp_pkg::frp_mode_t m, input frp_pkg::frp_pol_t pl,
                                   input logic [FW-1:0] f, input logic signed [GW-1:0] g,
                                   input logic [FW-1:0] ft, input logic [FW-1:0] gt);
    logic fu;
    logic fo;
    logic gc;
    logic signed [GW-1:0] t;
    t  = $signed({1'b0, gt});
    fu = (f != '0) && (f < ft);
    fo = f > ft;
    case (pl)
      frp_pkg::P_POS: gc = g > t;
      frp_pkg::P_NEG: gc = g < -t;
      frp_pkg::P_ABS: gc = (g > t) || (g < -t);
      default:        gc = 1'b0;
    endcase
    case (m)
      frp_pkg::M_UNDER:      ph_pick = fu;
      frp_pkg::M_OVER:       ph_pick = fo;
      frp_pkg::M_GRAD:       ph_pick = gc;
      frp_pkg::M_UNDER_GRAD: ph_pick = fu && gc;
      frp_pkg::M_OVER_GRAD:  ph_pick = fo && gc;
      default:               ph_pick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [FW-1:0]        volt [NP];
  logic [FW-1:0]        fin  [NP];
  logic [FW-1:0]        freq [NP];
  logic [FW-1:0]        hist [NP][10];
  logic [4:0]           seen [NP];
  logic [3:0]           run  [NP];
  logic signed [GW-1:0] graw [NP];
  logic signed [GW-1:0] grad [NP];
  logic [FW-1:0]        vblock;
  logic [3:0]           win;
  logic [3:0]           stabf;
  logic [3:0]           stabg;
  frp_pkg::frp_mode_t   mode [NE];
  frp_pkg::frp_pol_t    pol  [NE];
  logic [FW-1:0]        fthr [NE];
  logic [FW-1:0]        gthr [NE];
  logic [31:0]          dly  [NE];
  logic [31:0]          tmr  [NE];
  logic [NE-1:0]        pick;
  logic [NE-1:0]        blk_meta;
  logic [NE-1:0]        blk_s;
  frp_pkg::frp_blk_t    bstate;
  logic [31:0]          hold;
  logic                 all_low;
  logic                 freq_zero;
  logic                 wr;
  logic [31:0]          rd;
  logic [31:0]          wcfg_new;

  assign volt[0] = LINE_VOLTAGE_A_B;
  assign volt[1] = LINE_VOLTAGE_B_C;
  assign volt[2] = LINE_VOLTAGE_C_A;
  assign fin[0]  = FREQ_A_B;
  assign fin[1]  = FREQ_B_C;
  assign fin[2]  = FREQ_C_A;

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end
  end

  always_comb begin
    rd = 32'h0;
    if (WB_ADR_I == frp_pkg::ADR_VBLOCK) begin
      rd = {16'h0, vblock};
    end else if (WB_ADR_I == frp_pkg::ADR_WINCFG) begin
      rd[frp_pkg::WIN_LSB +: 4]   = win;
      rd[frp_pkg::STABF_LSB +: 4] = stabf;
      rd[frp_pkg::STABG_LSB +: 4] = stabg;
    end else if (WB_ADR_I == frp_pkg::ADR_STATUS) begin
      rd[NE-1:0]                     = ALARM;
      rd[frp_pkg::TRIP_LSB +: NE]    = TRIP;
      rd[frp_pkg::BLK_BIT]           = FREQ_BLOCKED;
    end
    for (int p = 0; p < NP; p++) begin
      if (WB_ADR_I == frp_pkg::ADR_GRAD0 + 8'(4 * p)) begin
        rd = 32'(grad[p]);
      end
    end
    for (int e = 0; e < NE; e++) begin
      if (elem_hit({WB_ADR_I[7:4], 4'h0}, 3'(e))) begin
        case (WB_ADR_I[3:2])
          frp_pkg::EL_MODE:  rd = {26'h0, pol[e], 1'b0, mode[e]};
          frp_pkg::EL_FTHR:  rd = {16'h0, fthr[e]};
          frp_pkg::EL_GTHR:  rd = {16'h0, gthr[e]};
          default:           rd = dly[e];
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_DAT_O <= 32'h0;
    end else if (WB_CYC_I && WB_STB_I && !WB_ACK_O) begin
      WB_DAT_O <= rd;
    end
  end

  // Global settings; window clamped to its legal span
  assign wcfg_new = merge({12'h0, stabg, 4'h0, stabf, 4'h0, win}, WB_DAT_I, WB_SEL_I);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      vblock <= frp_pkg::VBLOCK_RST;
      win    <= frp_pkg::WIN_RST;
      stabf  <= frp_pkg::STABF_RST;
      stabg  <= frp_pkg::STABG_RST;
    end else if (wr && WB_ADR_I == frp_pkg::ADR_VBLOCK) begin
      vblock <= 16'(merge({16'h0, vblock}, WB_DAT_I, WB_SEL_I));
    end else if (wr && WB_ADR_I == frp_pkg::ADR_WINCFG) begin
      if (wcfg_new[3:0] < frp_pkg::WIN_MIN) begin
        win <= frp_pkg::WIN_MIN;
      end else if (wcfg_new[3:0] > frp_pkg::WIN_MAX) begin
        win <= frp_pkg::WIN_MAX;
      end else begin
        win <= wcfg_new[3:0];
      end
      stabf <= wcfg_new[frp_pkg::STABF_LSB +: 4];
      stabg <= wcfg_new[frp_pkg::STABG_LSB +: 4];
    end
  end

  // ----------------------------------------
  // Voltage blocking
  // ----------------------------------------
  always_comb begin
    all_low = 1'b1;
    for (int p = 0; p < NP; p++) begin
      all_low = all_low && (volt[p] < vblock);
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      bstate <= frp_pkg::S_BLOCKED;
      hold   <= 32'h0;
    end else begin
      case (bstate)
        frp_pkg::S_RUN: begin
          if (all_low) begin
            bstate <= frp_pkg::S_BLOCKED;
          end
        end
        frp_pkg::S_BLOCKED: begin
          hold <= 32'h0;
          if (!all_low) begin
            bstate <= frp_pkg::S_RECOVER;
          end
        end
        frp_pkg::S_RECOVER: begin
          if (all_low) begin
            bstate <= frp_pkg::S_BLOCKED;
          end else if (hold >= 32'(BLOCK_HOLD - 1)) begin
            bstate <= frp_pkg::S_RUN;
          end else begin
            hold <= hold + 32'h1;
          end
        end
        default: bstate <= frp_pkg::S_BLOCKED;
      endcase
    end
  end

  assign FREQ_BLOCKED = bstate != frp_pkg::S_RUN;
  assign freq_zero = (bstate == frp_pkg::S_BLOCKED) ||
                     (bstate == frp_pkg::S_RECOVER && hold < 32'(FREQ_HOLD));

  // ----------------------------------------
  // Per phase frequency and gradient
  // ----------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_ph
    logic signed [GW-1:0] diff;
    logic [3:0]           next_run;
    assign diff = $signed({1'b0, fin[p]}) - $signed({1'b0, hist[p][win - 4'h1]});
    always_comb begin
      next_run = 4'h1;
      if (diff != '0 && graw[p] != '0 && diff[GW-1] == graw[p][GW-1] && run[p] != 4'hF) begin
        next_run = run[p] + 4'h1;
      end
    end

    always_ff @(posedge CLK) begin
      if (ZERO_CROSS[p]) begin
        hist[p][0] <= fin[p];
        for (int k = 1; k < 10; k++) begin
          hist[p][k] <= hist[p][k-1];
        end
      end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        freq[p] <= '0;
        seen[p] <= 5'h0;
        run[p]  <= 4'h0;
        graw[p] <= '0;
        grad[p] <= '0;
      end else if (freq_zero) begin
        freq[p] <= '0;
        seen[p] <= 5'h0;
        run[p]  <= 4'h0;
        graw[p] <= '0;
        grad[p] <= '0;
      end else if (ZERO_CROSS[p]) begin
        freq[p] <= fin[p];
        if (seen[p] != 5'h1F) begin
          seen[p] <= seen[p] + 5'h1;
        end
        if (seen[p] >= {1'b0, win} + {1'b0, stabf}) begin
          graw[p] <= diff;
          run[p]  <= next_run;
          grad[p] <= (next_run >= stabg) ? diff : '0;
        end
      end
    end
  end

  // ----------------------------------------
  // Protection elements
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      blk_meta <= '0;
      blk_s    <= '0;
    end else begin
      blk_meta <= ELEM_BLOCK;
      blk_s    <= blk_meta;
    end
  end

  for (genvar e = 0; e < NE; e++) begin : g_el
    logic        any;
    logic [31:0] mode_new;
    always_comb begin
      any = 1'b0;
      for (int p = 0; p < NP; p++) begin
        any = any || ph_pick(mode[e], pol[e], freq[p], grad[p], fthr[e], gthr[e]);
      end
    end
    assign pick[e] = any && !FREQ_BLOCKED && !blk_s[e];
    assign mode_new = merge({26'h0, pol[e], 1'b0, mode[e]}, WB_DAT_I, WB_SEL_I);

    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        mode[e] <= frp_pkg::M_OFF;
        pol[e]  <= frp_pkg::P_ABS;
        fthr[e] <= '0;
        gthr[e] <= '0;
        dly[e]  <= 32'h0;
      end else if (wr && elem_hit({WB_ADR_I[7:4], 4'h0}, 3'(e))) begin
        case (WB_ADR_I[3:2])
          frp_pkg::EL_MODE: begin
            mode[e] <= (mode_new[2:0] > 3'h5) ? frp_pkg::M_OFF
                                              : frp_pkg::frp_mode_t'(mode_new[2:0]);
            pol[e]  <= (mode_new[frp_pkg::POL_LSB +: 2] == 2'h3) ? frp_pkg::P_ABS
                       : frp_pkg::frp_pol_t'(mode_new[frp_pkg::POL_LSB +: 2]);
          end
          frp_pkg::EL_FTHR: begin
            fthr[e] <= 16'(merge({16'h0, fthr[e]}, WB_DAT_I, WB_SEL_I));
          end
          frp_pkg::EL_GTHR: begin
            gthr[e] <= 16'(merge({16'h0, gthr[e]}, WB_DAT_I, WB_SEL_I));
          end
          default: dly[e] <= merge(dly[e], WB_DAT_I, WB_SEL_I);
        endcase
      end
    end

    // Delay timer restarts whenever the condition drops
    always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
        tmr[e]   <= 32'h0;
        ALARM[e] <= 1'b0;
        TRIP[e]  <= 1'b0;
      end else begin
        ALARM[e] <= pick[e];
        TRIP[e]  <= pick[e] && (tmr[e] == dly[e]);
        if (!pick[e]) begin
          tmr[e] <= 32'h0;
        end else if (tmr[e] != dly[e]) begin
          tmr[e] <= tmr[e] + 32'h1;
        end
      end
    end

    // ----------------------------------------
    // Element checks
    // ----------------------------------------
    property p_alarm;
      @(posedge CLK) disable iff (!RESETN) $rose(pick[e]) |=> ALARM[e];
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm late");

    property p_trip_delay;
      @(posedge CLK) disable iff (!RESETN)
        $rose(TRIP[e]) |-> $past(pick[e]) && $past(tmr[e]) == $past(dly[e]);
    endproperty
    a_trip_delay: assert property (p_trip_delay) else $error("trip early");

    property p_trip_alarm;
      @(posedge CLK) disable iff (!RESETN) TRIP[e] |-> ALARM[e];
    endproperty
    a_trip_alarm: assert property (p_trip_alarm) else $error("trip alone");

    property p_drop;
      @(posedge CLK) disable iff (!RESETN) !pick[e] |=> !ALARM[e] && !TRIP[e] && tmr[e] == 0;
    endproperty
    a_drop: assert property (p_drop) else $error("no clear");

    property p_ext_block;
      @(posedge CLK) disable iff (!RESETN) blk_s[e] |=> !ALARM[e];
    endproperty
    a_ext_block: assert property (p_ext_block) else $error("block ignored");

    property p_mode_legal;
      @(posedge CLK) disable iff (!RESETN) mode[e] <= frp_pkg::M_OVER_GRAD;
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("bad mode");

    c_trip: cover property (@(posedge CLK) disable iff (!RESETN) $rose(TRIP[e]));
  end

  // ----------------------------------------
  // Block checks
  // ----------------------------------------
  property p_ack_pulse;
    @(posedge CLK) disable iff (!RESETN) WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

  property p_all_low;
    @(posedge CLK) disable iff (!RESETN) all_low |=> FREQ_BLOCKED;
  endproperty
  a_all_low: assert property (p_all_low) else $error("no blocking");

  property p_hold;
    @(posedge CLK) disable iff (!RESETN)
      $fell(all_low) |=> (FREQ_BLOCKED && freq[0] == 0) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("hold short");

  property p_window;
    @(posedge CLK) disable iff (!RESETN) win >= frp_pkg::WIN_MIN && win <= frp_pkg::WIN_MAX;
  endproperty
  a_window: assert property (p_window) else $error("window out of span");

  property p_sign;
    @(posedge CLK) disable iff (!RESETN)
      ZERO_CROSS[0] && !freq_zero && seen[0] >= {1'b0, win} + {1'b0, stabf} &&
      fin[0] > hist[0][win - 4'h1] |=> !graw[0][GW-1];
  endproperty
  a_sign: assert property (p_sign) else $error("gradient sign");

  c_alarm: cover property (@(posedge CLK) disable iff (!RESETN) $rose(ALARM[0]));
  c_recover: cover property (@(posedge CLK) disable iff (!RESETN) $fell(FREQ_BLOCKED));
  c_grad: cover property (@(posedge CLK) disable iff (!RESETN) grad[0] != 0);
endmodule

// ===== tb/frp_front_end.sv
// Purpose: Behavioural three-phase measurement front end
// Assumes: One zero crossing per phase every PERIOD clocks
// Notes:   Frequency is valid only in the crossing cycle
`timescale 1ns/1ps
module frp_front_end #(
  parameter int PERIOD = 16
) (
  // Clock and reset
  input  wire logic               CLK,
  input  wire logic               RESETN,
  // Bench control
  input  wire logic        [15:0] VOLT,
  input  wire logic        [15:0] FREQ_INIT,
  input  wire logic               FREQ_LOAD,
  input  wire logic signed [15:0] STEP,
  // Measurement outputs
  output logic             [15:0] LINE_VOLTAGE_A_B,
  output logic             [15:0] LINE_VOLTAGE_B_C,
  output logic             [15:0] LINE_VOLTAGE_C_A,
  output logic             [15:0] FREQ_A_B,
  output logic             [15:0] FREQ_B_C,
  output logic             [15:0] FREQ_C_A,
  output logic             [2:0]  ZERO_CROSS
);
  logic [15:0] freq;
  int          cnt;
  assign LINE_VOLTAGE_A_B = VOLT;
  assign LINE_VOLTAGE_B_C = VOLT;
  assign LINE_VOLTAGE_C_A = VOLT;
  // Stale value is inverted outside the crossing cycle
  assign FREQ_A_B = ZERO_CROSS[0] ? freq : ~freq;
  assign FREQ_B_C = ZERO_CROSS[1] ? freq : ~freq;
  assign FREQ_C_A = ZERO_CROSS[2] ? freq : ~freq;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt        <= 0;
      freq       <= 16'h03E8;
      ZERO_CROSS <= 3'h0;
    end else begin
      cnt        <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      ZERO_CROSS <= (cnt == PERIOD - 1) ? 3'h7 : 3'h0;
      if (FREQ_LOAD) begin
        freq <= FREQ_INIT;
      end else if (cnt == PERIOD - 1) begin
        freq <= freq + STEP;
      end
    end
  end
endmodule

// ===== tb/test_frequency_rocof_protection.sv
// Purpose: Self-checking bench of the frequency protection block
// Assumes: Short hold parameters, 16 clock mains period
// Notes:   Gradient reads in frequency codes per window
`timescale 1ns/1ps
module test_frequency_rocof_protection;
  logic               clk;
  logic               resetn;
  logic               cyc;
  logic               stb;
  logic               we;
  logic        [7:0]  adr;
  logic        [3:0]  sel;
  logic        [31:0] dat_i;
  logic        [31:0] dat_o;
  logic               ack;
  logic        [15:0] v_ab;
  logic        [15:0] v_bc;
  logic        [15:0] v_ca;
  logic        [15:0] f_ab;
  logic        [15:0] f_bc;
  logic        [15:0] f_ca;
  logic        [2:0]  zc;
  logic        [5:0]  elem_block;
  logic        [5:0]  alarm;
  logic        [5:0]  trip;
  logic               blocked;
  logic        [15:0] volt;
  logic        [15:0] f_init;
  logic               f_load;
  logic signed [15:0] step;
  int                 n_fail;
  int                 total_checks;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  frp_top #(.BLOCK_HOLD(20), .FREQ_HOLD(12)) DUT (
    .CLK(clk), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .LINE_VOLTAGE_A_B(v_ab), .LINE_VOLTAGE_B_C(v_bc), .LINE_VOLTAGE_C_A(v_ca),
    .FREQ_A_B(f_ab), .FREQ_B_C(f_bc), .FREQ_C_A(f_ca), .ZERO_CROSS(zc),
    .ELEM_BLOCK(elem_block), .ALARM(alarm), .TRIP(trip), .FREQ_BLOCKED(blocked));
  frp_front_end #(.PERIOD(16)) front (
    .CLK(clk), .RESETN(resetn), .VOLT(volt), .FREQ_INIT(f_init), .FREQ_LOAD(f_load),
    .STEP(step), .LINE_VOLTAGE_A_B(v_ab), .LINE_VOLTAGE_B_C(v_bc),
    .LINE_VOLTAGE_C_A(v_ca), .FREQ_A_B(f_ab), .FREQ_B_C(f_bc), .FREQ_C_A(f_ca),
    .ZERO_CROSS(zc));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic check_bit(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check_word(nm, exp, q);
  endtask
  task automatic cfg(input int e, input logic [2:0] m, input logic [1:0] p,
                     input logic [15:0] fthr, input logic [31:0] dly);
    logic [7:0] b;
    b = 8'h40 + 8'(16 * e);
    wr(b + 8'h04, {16'h0, fthr});
    wr(b + 8'h08, 32'h0000_0004);
    wr(b + 8'h0C, dly);
    wr(b, {26'h0, p, 1'b0, m});
  endtask
  task automatic wait_out(input logic is_trip, input int e, input logic v, input int lim);
    int n;
    n = 0;
    while ((is_trip ? trip[e] : alarm[e]) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic set_freq(input logic [15:0] f, input logic signed [15:0] s);
    f_init <= f;
    step   <= s;
    f_load <= 1'b1;
    @(posedge clk);
    f_load <= 1'b0;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd("vblock", 8'h00, 32'h0000_0100);
    rd("wincfg", 8'h04, 32'h0001_0302);
    rd("unmapped", 8'hFC, 32'h0000_0000);
    rd("status", 8'h08, 32'h0001_0000);
    wr(8'h04, 32'h0001_030C);
    rd("win_clamp", 8'h04, 32'h0001_030A);
    wr(8'h04, 32'h0001_0302);
    wr(8'h40, 32'h0000_0037);
    rd("mode_decode", 8'h40, 32'h0000_0020);
    wr(8'h5C, 32'h0000_00A5);
    rd("delay", 8'h5C, 32'h0000_00A5);
    rd("grad_blk", 8'h14, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task automatic t_block();
    repeat (20) @(posedge clk);
    check_bit("blocked_low", 1'b1, blocked);
    volt <= 16'h0200;
    repeat (12) @(posedge clk);
    check_bit("blocked_hold", 1'b1, blocked);
    repeat (20) @(posedge clk);
    check_bit("blocked_free", 1'b0, blocked);
    $display("t_block done");
  endtask
  task automatic t_under();
    set_freq(16'h03DE, 16'sh0);
    cfg(0, 3'h1, 2'h2, 16'h03E8, 32'h8);
    wait_out(1'b0, 0, 1'b1, 80);
    check_bit("under_alarm", 1'b1, alarm[0]);
    repeat (5) @(posedge clk);
    check_bit("under_early", 1'b0, trip[0]);
    wait_out(1'b1, 0, 1'b1, 6);
    check_bit("under_trip", 1'b1, trip[0]);
    set_freq(16'h03F2, 16'sh0);
    wait_out(1'b0, 0, 1'b0, 40);
    check_bit("under_clear", 1'b0, trip[0]);
    cfg(0, 3'h0, 2'h2, 16'h0, 32'h0);
    $display("t_under done");
  endtask
  task automatic t_over();
    cfg(1, 3'h2, 2'h2, 16'h03E8, 32'h8);
    wait_out(1'b0, 1, 1'b1, 80);
    check_bit("over_alarm", 1'b1, alarm[1]);
    elem_block <= 6'h02;
    wait_out(1'b0, 1, 1'b0, 6);
    check_bit("blk_alarm", 1'b0, alarm[1]);
    repeat (12) @(posedge clk);
    check_bit("blk_trip", 1'b0, trip[1]);
    elem_block <= 6'h00;
    wait_out(1'b1, 1, 1'b1, 16);
    check_bit("over_trip", 1'b1, trip[1]);
    cfg(1, 3'h0, 2'h2, 16'h0, 32'h0);
    $display("t_over done");
  endtask
  task automatic t_grad();
    for (int i = 0; i < 3; i++) cfg(2 + i, 3'h3, 2'(i), 16'h0, 32'h0);
    set_freq(16'h03E8, 16'sh5);
    repeat (200) @(posedge clk);
    rd("grad_up", 8'h0C, 32'h0000_000A);
    rd("grad_up_bc", 8'h10, 32'h0000_000A);
    check_word("alarm_up", 32'h14, {26'h0, alarm});
    check_bit("grad_trip", 1'b1, trip[2]);
    set_freq(16'h03E8, -16'sh5);
    repeat (200) @(posedge clk);
    rd("grad_down", 8'h0C, 32'hFFFF_FFF6);
    check_word("alarm_down", 32'h18, {26'h0, alarm});
    for (int i = 0; i < 3; i++) cfg(2 + i, 3'h0, 2'h2, 16'h0, 32'h0);
    $display("t_grad done");
  endtask
  task automatic t_comb();
    cfg(5, 3'h4, 2'h1, 16'h03E8, 32'h8);
    wait_out(1'b0, 5, 1'b1, 120);
    check_bit("comb_alarm", 1'b1, alarm[5]);
    wait_out(1'b1, 5, 1'b1, 12);
    check_bit("comb_trip", 1'b1, trip[5]);
    set_freq(16'h0384, 16'sh5);
    wait_out(1'b0, 5, 1'b0, 80);
    check_bit("comb_drop", 1'b0, trip[5]);
    cfg(4, 3'h5, 2'h0, 16'h0384, 32'h8);
    wait_out(1'b0, 4, 1'b1, 40);
    check_bit("og_alarm", 1'b1, alarm[4]);
    wait_out(1'b1, 4, 1'b1, 12);
    check_bit("og_trip", 1'b1, trip[4]);
    set_freq(16'h03E8, -16'sh5);
    wait_out(1'b0, 5, 1'b1, 120);
    volt <= 16'h0080;
    repeat (4) @(posedge clk);
    check_bit("relock", 1'b1, blocked);
    wait_out(1'b0, 5, 1'b0, 6);
    check_bit("relock_alarm", 1'b0, alarm[5]);
    $display("t_comb done");
  endtask
  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    n_fail       = 0;
    total_checks = 0;
    resetn       = 1'b0;
    {cyc, stb, we, adr, sel, dat_i, elem_block} = '0;
    volt   = 16'h0000;
    f_init = 16'h03E8;
    f_load = 1'b0;
    step   = 16'sh0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_block();
    t_under();
    t_over();
    t_grad();
    t_comb();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
